// ### pcr_config_space.v
// PCS configuration and status register space on the 32-bit control port
//
// Functional notes
// - Each register is one 16-bit word.
// - Upper bus half reads as zero.
// - Combined variant places word zero at 0x80.
// - Control word RW, resets to 0x1140.
// - Status word RO, resets to 0x0089.
// - Identifier halves at 0x02 and 0x03.
// - Advertisement word RW, resets to 0x01A0.
// - SGMII MAC mode ignores the advertisement word.
// - Partner ability RO, loaded, resets zero.
// - Expansion word RO, resets zero.
// - Words 0x07 to 0x0A read zero always.
// - Word 0x14 selects 1000BASE-X or SGMII.
`timescale 1ns/1ns
`default_nettype none
`include "pcr_config_map.vh"

module pcr_config_space #(
	parameter        COMBINED              = 1,
	// Identifier value is arbitrary
	parameter [31:0] IDENT_BUILD_PARAMETER = 32'h5A5A_0000
) (
	input  wire                   clk,
	input  wire                   nrst,
	input  wire [`PCR_ADDR_W-1:0] regAddr,
	input  wire                   regRead,
	input  wire                   regWrite,
	input  wire [`PCR_BUS_W-1:0]  regWriteData,
	output reg  [`PCR_BUS_W-1:0]  regReadData,
	output reg                    regReadValid,
	output wire                   regWaitRequest,
	input  wire                   linkUp,
	input  wire                   anDone,
	input  wire [`PCR_WORD_W-1:0] partnerAbility,
	input  wire                   partnerLoad,
	input  wire                   pageReceived,
	output wire                   pcsSoftReset,
	output wire                   loopbackEn,
	output wire                   anEnable,
	output wire                   anRestart,
	output wire                   powerDown,
	output wire                   unidirEn,
	output wire                   sgmiiEnable,
	output wire                   sgmiiMacMode,
	output reg  [`PCR_WORD_W-1:0] advertTx,
	output reg                    advertInUse
);

	localparam NUM_RW = 3;

	// Per-register offsets, reset values and masks, highest entry first
	localparam [NUM_RW*`PCR_OFF_W-1:0] RW_OFF = {
		`PCR_OFF_IF_MODE,
		`PCR_OFF_ADVERT,
		`PCR_OFF_CONTROL
	};
	localparam [NUM_RW*`PCR_WORD_W-1:0] RW_RST = {
		`PCR_RST_IF_MODE,
		`PCR_RST_ADVERT,
		`PCR_RST_CONTROL
	};
	localparam [NUM_RW*`PCR_WORD_W-1:0] RW_WMASK = {
		`PCR_WMASK_IF_MODE,
		`PCR_WMASK_ADVERT,
		`PCR_WMASK_CONTROL
	};
	localparam [NUM_RW*`PCR_WORD_W-1:0] RW_SCLR = {
		`PCR_SCLR_NONE,
		`PCR_SCLR_NONE,
		`PCR_SCLR_CONTROL
	};

	// Address decode
	wire                   hit;
	wire [`PCR_OFF_W-1:0]  wordOff;
	wire                   wrAccess;
	wire                   rdAccess;
	wire [`PCR_WORD_W-1:0] wrWord;

	// Writable words
	wire [NUM_RW*`PCR_WORD_W-1:0] rwQ;
	wire [`PCR_WORD_W-1:0]        controlWord;
	wire [`PCR_WORD_W-1:0]        advertWord;
	wire [`PCR_WORD_W-1:0]        ifModeWord;

	// Hardware-updated words and identifier halves
	reg  [`PCR_WORD_W-1:0] remoteWord;
	reg  [`PCR_WORD_W-1:0] next_remoteWord;
	reg  [`PCR_WORD_W-1:0] expansionWord;
	reg  [`PCR_WORD_W-1:0] next_expansionWord;
	reg                    linkLatched;
	reg                    next_linkLatched;
	reg  [`PCR_WORD_W-1:0] statusWord;
	wire [`PCR_WORD_W-1:0] identHigh;
	wire [`PCR_WORD_W-1:0] identLow;

	// Unsupported next-page and leader/follower words
	wire [`PCR_WORD_W-1:0] localNextPage;
	wire [`PCR_WORD_W-1:0] remoteNextPage;
	wire [`PCR_WORD_W-1:0] leaderFollowerControl;
	wire [`PCR_WORD_W-1:0] leaderFollowerStat;

	// Read path
	reg  [`PCR_WORD_W-1:0] rdWord;
	reg  [`PCR_BUS_W-1:0]  next_regReadData;
	wire                   statusRead;
	wire                   expansionRead;
	wire                   reservedWord;

	pcr_addr_decode #(
		.COMBINED (COMBINED)
	) uDecode (
		.addr    (regAddr),
		.hit     (hit),
		.wordOff (wordOff)
	);

	// Addresses outside the PCS window are ignored on write and read zero
	assign wrAccess = regWrite & hit;
	assign rdAccess = regRead & hit;

	// Only the low half of the bus carries a word
	assign wrWord = regWriteData[`PCR_WORD_W-1:0];

	// Every access is accepted in its own cycle; read data follows one cycle later
	assign regWaitRequest = 1'b0;

	// Writable words: control, advertisement, interface mode
	genvar i;
	generate
		for (i = 0; i < NUM_RW; i = i + 1) begin : gRw
			wire wrSel;

			assign wrSel = wrAccess &&
				(wordOff == RW_OFF[i*`PCR_OFF_W +: `PCR_OFF_W]);

			pcr_word_reg #(
				.RESET_VALUE (RW_RST[i*`PCR_WORD_W +: `PCR_WORD_W]),
				.WRITE_MASK  (RW_WMASK[i*`PCR_WORD_W +: `PCR_WORD_W]),
				.SCLR_MASK   (RW_SCLR[i*`PCR_WORD_W +: `PCR_WORD_W])
			) uWord (
				.clk    (clk),
				.nrst   (nrst),
				.wrEn   (wrSel),
				.wrData (wrWord),
				.q      (rwQ[i*`PCR_WORD_W +: `PCR_WORD_W])
			);
		end
	endgenerate

	assign controlWord = rwQ[0*`PCR_WORD_W +: `PCR_WORD_W];
	assign advertWord  = rwQ[1*`PCR_WORD_W +: `PCR_WORD_W];
	assign ifModeWord  = rwQ[2*`PCR_WORD_W +: `PCR_WORD_W];

	// Control fields steering the PCS
	assign pcsSoftReset = controlWord[`PCR_CTL_RESET];
	assign loopbackEn   = controlWord[`PCR_CTL_LOOPBACK];
	assign anEnable     = controlWord[`PCR_CTL_AN_ENABLE];
	assign anRestart    = controlWord[`PCR_CTL_AN_RESTART];
	assign powerDown    = controlWord[`PCR_CTL_POWER_DOWN];

	// Unidirectional bit has no effect while negotiation is on
	assign unidirEn = controlWord[`PCR_CTL_UNIDIR] &
		~controlWord[`PCR_CTL_AN_ENABLE];

	// Interface mode selection
	assign sgmiiEnable  = ifModeWord[`PCR_IFM_SGMII];
	assign sgmiiMacMode = ifModeWord[`PCR_IFM_SGMII] &
		ifModeWord[`PCR_IFM_MAC_MODE];

	// Word offered to the negotiation engine
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			advertTx    <= `PCR_RST_ADVERT;
			advertInUse <= 1'b1;
		end else if (sgmiiMacMode) begin
			// Stored word stays readable but is not sent
			advertTx    <= `PCR_SGMII_MAC_ADVERT;
			advertInUse <= 1'b0;
		end else begin
			advertTx    <= advertWord;
			advertInUse <= 1'b1;
		end
	end

	// Partner abilities captured by the negotiation engine
	always @* begin
		next_remoteWord = remoteWord;
		if (partnerLoad) begin
			next_remoteWord = partnerAbility;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			remoteWord <= `PCR_RST_REMOTE;
		end else begin
			remoteWord <= next_remoteWord;
		end
	end

	assign statusRead    = rdAccess && (wordOff == `PCR_OFF_STATUS);
	assign expansionRead = rdAccess && (wordOff == `PCR_OFF_EXPANSION);

	// Link status latches low until the status word is read
	always @* begin
		next_linkLatched = linkLatched;
		if (statusRead) begin
			next_linkLatched = linkUp;
		end
		if (!linkUp) begin
			next_linkLatched = 1'b0;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			linkLatched <= 1'b0;
		end else begin
			linkLatched <= next_linkLatched;
		end
	end

	// Page-received flag clears on read; a new page in that cycle wins
	always @* begin
		next_expansionWord = expansionWord;
		if (expansionRead) begin
			next_expansionWord[`PCR_EXP_PAGE_RCVD] = 1'b0;
		end
		if (pageReceived) begin
			next_expansionWord[`PCR_EXP_PAGE_RCVD] = 1'b1;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			expansionWord <= `PCR_RST_EXPANSION;
		end else begin
			expansionWord <= next_expansionWord;
		end
	end

	// Status word: fixed ability bits plus latched link and live negotiation state
	always @* begin
		statusWord                   = `PCR_RST_STATUS;
		statusWord[`PCR_STS_LINK]    = linkLatched;
		statusWord[`PCR_STS_AN_DONE] = anDone;
	end

	// Identifier halves from the build parameter
	assign identHigh = IDENT_BUILD_PARAMETER[31:16];
	assign identLow  = IDENT_BUILD_PARAMETER[15:0];

	// No storage behind these words, so writes have nothing to change
	assign localNextPage         = `PCR_ZERO_WORD;
	assign remoteNextPage        = `PCR_ZERO_WORD;
	assign leaderFollowerControl = `PCR_ZERO_WORD;
	assign leaderFollowerStat    = `PCR_ZERO_WORD;

	// Reserved words: nothing stored, nothing returned
	assign reservedWord = (wordOff >= `PCR_OFF_RSVD_FIRST) &&
		(wordOff <= `PCR_OFF_RSVD_LAST);

	// Read multiplexer
	always @* begin
		rdWord = `PCR_ZERO_WORD;
		case (wordOff)
			`PCR_OFF_CONTROL: begin
				rdWord = controlWord;
			end
			`PCR_OFF_STATUS: begin
				rdWord = statusWord;
			end
			`PCR_OFF_IDENT_HIGH: begin
				rdWord = identHigh;
			end
			`PCR_OFF_IDENT_LOW: begin
				rdWord = identLow;
			end
			`PCR_OFF_ADVERT: begin
				rdWord = advertWord;
			end
			`PCR_OFF_REMOTE: begin
				rdWord = remoteWord;
			end
			`PCR_OFF_EXPANSION: begin
				rdWord = expansionWord;
			end
			`PCR_OFF_LOCAL_NP: begin
				rdWord = localNextPage;
			end
			`PCR_OFF_REMOTE_NP: begin
				rdWord = remoteNextPage;
			end
			`PCR_OFF_LF_CONTROL: begin
				rdWord = leaderFollowerControl;
			end
			`PCR_OFF_LF_STATUS: begin
				rdWord = leaderFollowerStat;
			end
			`PCR_OFF_IF_MODE: begin
				rdWord = ifModeWord;
			end
			default: begin
				// Reserved and unused words, including 0x0B to 0x0E
				rdWord = `PCR_ZERO_WORD;
			end
		endcase
		if (reservedWord) begin
			rdWord = `PCR_ZERO_WORD;
		end
	end

	// Read data for this cycle's request; other cycles keep the last word
	always @* begin
		next_regReadData = regReadData;
		if (rdAccess) begin
			next_regReadData = {`PCR_UPPER_ZERO, rdWord};
		end else if (regRead) begin
			// Reads outside the window return zero
			next_regReadData = {`PCR_BUS_W{1'b0}};
		end
	end

	// Registered read data, one cycle after the request
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regReadData  <= {`PCR_BUS_W{1'b0}};
			regReadValid <= 1'b0;
		end else begin
			regReadData  <= next_regReadData;
			regReadValid <= regRead;
		end
	end

endmodule
`default_nettype wire

// ### pcr_config_map.vh
// Offsets, field positions and reset values of the PCS configuration space
`ifndef PCR_CONFIG_MAP_VH
`define PCR_CONFIG_MAP_VH

// Bus and word geometry
`define PCR_WORD_W          16
`define PCR_BUS_W           32
`define PCR_ADDR_W          8
`define PCR_OFF_W           5
`define PCR_UPPER_ZERO      16'h0000
`define PCR_COMBINED_BASE   8'h80
`define PCR_STANDALONE_BASE 8'h00

// Word offsets
`define PCR_OFF_CONTROL     5'h00
`define PCR_OFF_STATUS      5'h01
`define PCR_OFF_IDENT_HIGH  5'h02
`define PCR_OFF_IDENT_LOW   5'h03
`define PCR_OFF_ADVERT      5'h04
`define PCR_OFF_REMOTE      5'h05
`define PCR_OFF_EXPANSION   5'h06
`define PCR_OFF_LOCAL_NP    5'h07
`define PCR_OFF_REMOTE_NP   5'h08
`define PCR_OFF_LF_CONTROL  5'h09
`define PCR_OFF_LF_STATUS   5'h0A
`define PCR_OFF_RSVD_FIRST  5'h0B
`define PCR_OFF_RSVD_LAST   5'h0E
`define PCR_OFF_IF_MODE     5'h14

// Reset values
`define PCR_RST_CONTROL     16'h1140
`define PCR_RST_STATUS      16'h0089
`define PCR_RST_ADVERT      16'h01A0
`define PCR_RST_REMOTE      16'h0000
`define PCR_RST_EXPANSION   16'h0000
`define PCR_RST_IF_MODE     16'h0000
`define PCR_ZERO_WORD       16'h0000

// Writable and self-clearing bits
`define PCR_WMASK_CONTROL   16'hDA20
`define PCR_SCLR_CONTROL    16'h8200
`define PCR_WMASK_ADVERT    16'hFFFF
`define PCR_WMASK_IF_MODE   16'h0003
`define PCR_SCLR_NONE       16'h0000

// Control bit positions
`define PCR_CTL_RESET       15
`define PCR_CTL_LOOPBACK    14
`define PCR_CTL_AN_ENABLE   12
`define PCR_CTL_POWER_DOWN  11
`define PCR_CTL_AN_RESTART  9
`define PCR_CTL_UNIDIR      5

// Status, expansion and mode bit positions
`define PCR_STS_LINK        2
`define PCR_STS_AN_DONE     5
`define PCR_EXP_PAGE_RCVD   1
`define PCR_IFM_SGMII       0
`define PCR_IFM_MAC_MODE    1

// Fixed word sent in place of the advertisement on the MAC side of SGMII
`define PCR_SGMII_MAC_ADVERT 16'h4001

`endif

// ### pcr_word_reg.v
// One 16-bit writable word with write mask and self-clearing bits
`timescale 1ns/1ns
`default_nettype none
`include "pcr_config_map.vh"

module pcr_word_reg #(
	parameter [`PCR_WORD_W-1:0] RESET_VALUE = `PCR_ZERO_WORD,
	parameter [`PCR_WORD_W-1:0] WRITE_MASK  = `PCR_ZERO_WORD,
	parameter [`PCR_WORD_W-1:0] SCLR_MASK   = `PCR_SCLR_NONE
) (
	input  wire                   clk,
	input  wire                   nrst,
	input  wire                   wrEn,
	input  wire [`PCR_WORD_W-1:0] wrData,
	output reg  [`PCR_WORD_W-1:0] q
);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= RESET_VALUE;
		end else if (wrEn) begin
			// Read-only bits keep their value
			q <= (q & ~WRITE_MASK) | (wrData & WRITE_MASK);
		end else begin
			q <= q & ~SCLR_MASK;
		end
	end

endmodule
`default_nettype wire

// ### pcr_addr_decode.v
// Maps a control-port address onto a PCS word offset
`timescale 1ns/1ns
`default_nettype none
`include "pcr_config_map.vh"

module pcr_addr_decode #(
	parameter COMBINED = 1
) (
	input  wire [`PCR_ADDR_W-1:0] addr,
	output wire                   hit,
	output wire [`PCR_OFF_W-1:0]  wordOff
);

	wire [`PCR_ADDR_W-1:0] base;
	wire [`PCR_ADDR_W-1:0] rel;

	// Combined variant sits at the PCS base, standalone at zero
	assign base    = (COMBINED != 0) ? `PCR_COMBINED_BASE : `PCR_STANDALONE_BASE;
	assign rel     = addr - base;
	assign hit     = (addr >= base) && (rel[`PCR_ADDR_W-1:`PCR_OFF_W] == 3'h0);
	assign wordOff = rel[`PCR_OFF_W-1:0];

endmodule
`default_nettype wire

// ### pcr_space_chk.sv
// Concurrent checks on the PCS register space ports
`timescale 1ns/1ns
`default_nettype none
module pcr_space_chk #(
	parameter        COMBINED              = 1,
	parameter [31:0] IDENT_BUILD_PARAMETER = 32'h0000_0000
) (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [7:0]  regAddr,
	input wire logic        regRead,
	input wire logic        regWrite,
	input wire logic [31:0] regWriteData,
	input wire logic [31:0] regReadData,
	input wire logic        regReadValid,
	input wire logic        regWaitRequest,
	input wire logic        anRestart,
	input wire logic        sgmiiMacMode,
	input wire logic [15:0] advertTx,
	input wire logic        advertInUse
);
	localparam [7:0] BASE = COMBINED ? 8'h80 : 8'h00;
	logic [7:0] off;
	assign off = regAddr - BASE;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_READ_VALID: assert property (regRead |=> regReadValid) else $error("read not answered");
	AST_NO_SPURIOUS: assert property (!regRead |=> !regReadValid) else $error("valid without read");
	AST_UPPER_ZERO: assert property (regReadValid |-> regReadData[31:16] == 16'h0000) else $error("upper half");
	AST_NO_STALL: assert property (regWaitRequest == 1'b0) else $error("port stalled");
	AST_IDENT_HIGH: assert property (regRead && off == 8'h02 |=>
		regReadData[15:0] == IDENT_BUILD_PARAMETER[31:16]) else $error("ident high");
	AST_IDENT_LOW: assert property (regRead && off == 8'h03 |=>
		regReadData[15:0] == IDENT_BUILD_PARAMETER[15:0]) else $error("ident low");
	AST_ZERO_WORDS: assert property (regRead && off >= 8'h07 && off <= 8'h0E |=>
		regReadData == 32'h0000_0000) else $error("zero word");
	AST_RESTART: assert property (regWrite && off == 8'h00 && regWriteData[9] |=>
		anRestart ##1 !anRestart) else $error("restart pulse");
	AST_MAC_ADVERT: assert property (sgmiiMacMode && $stable(sgmiiMacMode) |->
		advertTx == 16'h4001 && !advertInUse) else $error("advert in mac mode");
	COV_STATUS_READ: cover property (regRead && off == 8'h01);
	COV_CONTROL_WRITE: cover property (regWrite && off == 8'h00);
	COV_MAC_MODE: cover property (sgmiiMacMode);
endmodule
bind pcr_config_space pcr_space_chk #(.COMBINED(COMBINED), .IDENT_BUILD_PARAMETER(IDENT_BUILD_PARAMETER))
	pcr_space_chk_i (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
	.regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
	.regWaitRequest(regWaitRequest), .anRestart(anRestart), .sgmiiMacMode(sgmiiMacMode),
	.advertTx(advertTx), .advertInUse(advertInUse));
`default_nettype wire

// ### pcr_pcs_model.sv
// PCS-side model that negotiates a few cycles after a restart
`timescale 1ns/1ns
`default_nettype none
module pcr_pcs_model #(
	parameter [15:0] ABILITY = 16'hD801
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        anRestart,
	output var  logic        linkUp,
	output var  logic        anDone,
	output var  logic        partnerLoad,
	output var  logic        pageReceived,
	output var  logic [15:0] partnerAbility
);
	logic [2:0] cnt;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt            <= 3'h0;
			anDone         <= 1'b0;
			partnerLoad    <= 1'b0;
			pageReceived   <= 1'b0;
			partnerAbility <= 16'h0000;
		end else begin
			partnerLoad    <= (cnt == 3'h1);
			pageReceived   <= (cnt == 3'h1);
			// Word toggles outside the load pulse
			partnerAbility <= (cnt == 3'h1) ? ABILITY : ~partnerAbility;
			cnt            <= anRestart ? 3'h4 : (cnt != 3'h0) ? cnt - 3'h1 : cnt;
			anDone         <= anRestart ? 1'b0 : (cnt == 3'h1) ? 1'b1 : anDone;
		end
	end
	assign linkUp = anDone;
endmodule
`default_nettype wire

// ### pcr_config_space_bench.sv
// Self-checking bench for the PCS register space
`timescale 1ns/1ns
`default_nettype none
module pcr_config_space_bench;
	localparam [31:0] IDENT = 32'hC3A5_0F1E; // Arbitrary value
	localparam [15:0] ABIL  = 16'hD801;
	logic        clk, nrst, regRead, regWrite, regReadValid, regWaitRequest, linkUp, anDone, partnerLoad;
	logic        pageReceived, pcsSoftReset, loopbackEn, anEnable, anRestart, powerDown, unidirEn;
	logic        sgmiiEnable, sgmiiMacMode, advertInUse;
	logic [7:0]  regAddr;
	logic [15:0] partnerAbility, advertTx;
	logic [31:0] regWriteData, regReadData;
	logic        saRead, saWrite, saValid;
	logic [7:0]  saAddr;
	logic [31:0] saWData, saRData;
	int          num_errors = 0;
	int          checks_done = 0;
	pcr_config_space #(.COMBINED(1), .IDENT_BUILD_PARAMETER(IDENT)) pcr_config_space_i (
		.clk(clk), .nrst(nrst), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
		.regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
		.regWaitRequest(regWaitRequest), .linkUp(linkUp), .anDone(anDone), .partnerAbility(partnerAbility),
		.partnerLoad(partnerLoad), .pageReceived(pageReceived), .pcsSoftReset(pcsSoftReset),
		.loopbackEn(loopbackEn), .anEnable(anEnable), .anRestart(anRestart), .powerDown(powerDown),
		.unidirEn(unidirEn), .sgmiiEnable(sgmiiEnable), .sgmiiMacMode(sgmiiMacMode),
		.advertTx(advertTx), .advertInUse(advertInUse));
	pcr_pcs_model #(.ABILITY(ABIL)) pcr_pcs_model_i (
		.clk(clk), .nrst(nrst), .anRestart(anRestart), .linkUp(linkUp), .anDone(anDone),
		.partnerLoad(partnerLoad), .pageReceived(pageReceived), .partnerAbility(partnerAbility));
	// Standalone variant, reached with plain word offsets
	pcr_config_space #(.COMBINED(0), .IDENT_BUILD_PARAMETER(IDENT)) pcr_config_space_sa_i (
		.clk(clk), .nrst(nrst), .regAddr(saAddr), .regRead(saRead), .regWrite(saWrite),
		.regWriteData(saWData), .regReadData(saRData), .regReadValid(saValid), .regWaitRequest(),
		.linkUp(1'b0), .anDone(1'b0), .partnerAbility(16'h0000), .partnerLoad(1'b0), .pageReceived(1'b0),
		.pcsSoftReset(), .loopbackEn(), .anEnable(), .anRestart(), .powerDown(), .unidirEn(),
		.sgmiiEnable(), .sgmiiMacMode(), .advertTx(), .advertInUse());
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		logic [9:0] byteAddr;
		byteAddr = (10'h080 + {2'h0, off}) << 2;
		@(posedge clk);
		regWrite     <= 1'b1;
		regAddr      <= byteAddr[9:2];
		regWriteData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] off, input logic [31:0] exp);
		logic [9:0] byteAddr;
		byteAddr = (10'h080 + {2'h0, off}) << 2;
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= byteAddr[9:2];
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		chk({31'h0, regReadValid}, 32'h1);
		chk(regReadData, exp);
	endtask
	task automatic t_reset;
		chk({31'h0, anEnable}, 32'h1);
		rd(8'h00, 32'h0000_1140);
		rd(8'h01, 32'h0000_0089);
		rd(8'h02, {16'h0000, IDENT[31:16]});
		rd(8'h03, {16'h0000, IDENT[15:0]});
		rd(8'h04, 32'h0000_01A0);
		rd(8'h05, 32'h0);
		rd(8'h06, 32'h0);
		rd(8'h14, 32'h0);
	endtask
	task automatic t_control;
		wr(8'h00, 32'h0000_4820);
		rd(8'h00, 32'h0000_4960);
		chk({28'h0, loopbackEn, powerDown, anEnable, unidirEn}, 32'hD);
		wr(8'h00, 32'h0000_1340);
		#1;
		chk({31'h0, anRestart}, 32'h1);
		rd(8'h00, 32'h0000_1140);
		chk({28'h0, loopbackEn, powerDown, anEnable, unidirEn}, 32'h2);
		wr(8'h00, 32'h0000_9140);
		#1;
		chk({31'h0, pcsSoftReset}, 32'h1);
		@(posedge clk);
		#1;
		chk({31'h0, pcsSoftReset}, 32'h0);
		rd(8'h00, 32'h0000_1140);
		wr(8'h04, 32'hABCD_1234);
		rd(8'h04, 32'h0000_1234);
	endtask
	task automatic t_neg;
		int n;
		n = 0;
		while (anDone !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		rd(8'h05, {16'h0000, ABIL});
		rd(8'h06, 32'h0000_0002);
		rd(8'h06, 32'h0);
		rd(8'h01, 32'h0000_00A9);
		rd(8'h01, 32'h0000_00AD);
	endtask
	task automatic t_protect;
		for (int a = 1; a <= 14; a++) begin
			if (a != 4) wr(a[7:0], 32'h0000_FFFF);
		end
		rd(8'h01, 32'h0000_00AD);
		rd(8'h03, {16'h0000, IDENT[15:0]});
		rd(8'h05, {16'h0000, ABIL});
		for (int a = 6; a <= 14; a++) rd(a[7:0], 32'h0);
	endtask
	task automatic t_mode;
		wr(8'h14, 32'h0000_0003);
		repeat (2) @(posedge clk);
		#1;
		chk({30'h0, sgmiiEnable, sgmiiMacMode}, 32'h3);
		chk({15'h0, advertInUse, advertTx}, 32'h0000_4001);
		rd(8'h04, 32'h0000_1234);
		wr(8'h14, 32'h0000_0001);
		repeat (2) @(posedge clk);
		#1;
		chk({14'h0, sgmiiMacMode, advertInUse, advertTx}, 32'h0001_1234);
	endtask
	task automatic sa_wr(input logic [7:0] off, input logic [31:0] d);
		@(posedge clk);
		saWrite <= 1'b1;
		saAddr  <= off;
		saWData <= d;
		@(posedge clk);
		saWrite <= 1'b0;
	endtask
	task automatic sa_rd(input logic [7:0] off, input logic [31:0] exp);
		@(posedge clk);
		saRead <= 1'b1;
		saAddr <= off;
		@(posedge clk);
		saRead <= 1'b0;
		#1;
		chk({31'h0, saValid}, 32'h1);
		chk(saRData, exp);
	endtask
	task automatic t_standalone;
		sa_rd(8'h00, 32'h0000_1140);
		sa_wr(8'h14, 32'h0000_0001);
		sa_rd(8'h14, 32'h0000_0001);
		sa_rd(8'h02, {16'h0000, IDENT[31:16]});
		sa_rd(8'h94, 32'h0);
	endtask
	task automatic results;
		$display("Checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		nrst = 1'b0;
		regRead = 1'b0;
		regWrite = 1'b0;
		regAddr = 8'h00;
		regWriteData = 32'h0;
		saRead = 1'b0;
		saWrite = 1'b0;
		saAddr = 8'h00;
		saWData = 32'h0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_control();
		t_neg();
		t_protect();
		t_mode();
		t_standalone();
		results();
	end
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule
`default_nettype wire
